// ---- include/mcgc_pkg.sv ----
// Constants, register map and state codes for the Manchester line coder.
// Assumes a single 100 MHz clock and a 32-bit Avalon-MM register bus.
package mcgc_pkg;

  // ==========================================================================
  // Bus and register map (byte addresses)
  localparam int unsigned ADDR_W       = 16;
  localparam logic [15:0] CTL0_OFFSET  = 16'hff4c; // coder_control_0
  localparam logic [15:0] CTL1_OFFSET  = 16'hff50; // coder_control_1, half-bit divider
  localparam logic [15:0] CTL2_OFFSET  = 16'hff54; // coder_control_2, transmit data
  localparam logic [15:0] STAT_OFFSET  = 16'hff58; // coder status

  // ==========================================================================
  // coder_control_0 fields
  localparam int unsigned CTL0_POWER_BIT  = 7;
  localparam int unsigned CTL0_ORDER_BIT  = 4;
  localparam int unsigned CTL0_FORMAT_BIT = 1;
  localparam int unsigned CTL0_IDLE_BIT   = 0;
  localparam logic [7:0]  CTL0_RESET      = 8'h10;

  // ==========================================================================
  // Status fields
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_EMPTY_BIT = 1;
  localparam int unsigned STAT_FULL_BIT  = 2;
  localparam int unsigned STAT_LEVEL_LSB = 8;

  // ==========================================================================
  // Data path and timing
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned DIV_W        = 16;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned BIT_TIME_NS  = 1000;                          // Default bit time
  localparam int unsigned HALF_CYCLES  = (BIT_TIME_NS * CLK_MHZ) / 2000; // Cycles per half bit
  localparam logic [15:0] CTL1_RESET   = 16'(HALF_CYCLES - 1);

  // ==========================================================================
  // Transmitter states
  typedef enum logic [0:0] {
    MCGC_IDLE = 1'b0,
    MCGC_SEND = 1'b1
  } mcgc_tx_st_t;

endpackage : mcgc_pkg

// ---- core/mcgc_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and one clock with a clock enable.
`timescale 1ns/10ps
`default_nettype none
module mcgc_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          wr_valid_i,
  input  wire logic [W-1:0]  wr_data_i,
  output logic               wr_ready_o,
  output logic               rd_valid_o,
  output logic [W-1:0]       rd_data_o,
  input  wire logic          rd_ready_i,
  output logic [AW:0]        level_o
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wptr;
    logic [AW:0]             rptr;
  } mcgc_fifo_st_t;

  mcgc_fifo_st_t r;
  mcgc_fifo_st_t n;

  // ==========================================================================
  // Flags from the pointers, one wrap bit above the index
  assign level_o    = r.wptr - r.rptr;
  assign wr_ready_o = (level_o != (AW+1)'(DEPTH));
  assign rd_valid_o = (r.wptr != r.rptr);
  assign rd_data_o  = r.mem[r.rptr[AW-1:0]];

  // ==========================================================================
  // Next state: push and pop may happen in the same cycle
  always_comb begin
    n = r;
    if (ce_i && wr_valid_i && wr_ready_o) begin
      n.mem[r.wptr[AW-1:0]] = wr_data_i;
      n.wptr                = r.wptr + 1'b1;
    end
    if (ce_i && rd_valid_o && rd_ready_i) begin
      n.rptr = r.rptr + 1'b1;
    end
  end

  // Pointers clear on reset; storage contents need no reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.mem  <= n.mem;
      r.wptr <= '0;
      r.rptr <= '0;
    end else begin
      r <= n;
    end
  end

endmodule // mcgc_fifo
`default_nettype wire

// ---- core/mcgc_top.sv ----
// Manchester / plain serial line coder with an Avalon-MM register slave.
// Assumes mclk_i at 100 MHz, synchronous active-high reset, and a
// clock enable that freezes every flip-flop while low.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - The coded bit stream leaves the block on coded_output_pin_o.
// - Control bit 7 stops the coder when zero and runs it when one.
// - Control bit 4 sends the word MSB first when zero and LSB first when one.
// - Control bit 1 picks Manchester coding when zero and plain bit-sequential when one.
// - Control bit 0 is the line level held while nothing is being sent.
// - The control register resets to 10H and its bits 6, 5, 3 and 2 read zero.
module mcgc_top
  import mcgc_pkg::*;
#(
  parameter int unsigned DW    = DATA_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic                   coded_output_pin_o
);

  localparam int unsigned BW = $clog2(DW);
  localparam int unsigned LW = $clog2(DEPTH) + 1;

  // ==========================================================================
  // State record
  typedef struct packed {
    logic                 power;      // coder_power_on
    logic                 lsb_first;  // first_bit_order
    logic                 plain;      // output_format_select
    logic                 idle_lvl;   // idle_output_level
    logic [DIV_W-1:0]     half_div;   // Half-bit length minus one
    logic                 waitreq;    // Bus wait flag, low for the answer cycle
    logic [31:0]          rdata;      // Read data held for the answer cycle
    mcgc_tx_st_t          st;         // Transmitter state
    logic [DW-1:0]        shreg;      // Word being sent
    logic [BW-1:0]        bitcnt;     // Bits left after the current one
    logic                 half;       // Second half of the current bit
    logic [DIV_W-1:0]     cnt;        // Cycles left in the current half
    logic                 pin;        // Registered line level
  } mcgc_state_t;

  localparam mcgc_state_t RESET_ST = '{
    power:     CTL0_RESET[CTL0_POWER_BIT],
    lsb_first: CTL0_RESET[CTL0_ORDER_BIT],
    plain:     CTL0_RESET[CTL0_FORMAT_BIT],
    idle_lvl:  CTL0_RESET[CTL0_IDLE_BIT],
    half_div:  CTL1_RESET,
    waitreq:   1'b1,
    rdata:     32'h0000_0000,
    st:        MCGC_IDLE,
    shreg:     '0,
    bitcnt:    '0,
    half:      1'b0,
    cnt:       '0,
    pin:       CTL0_RESET[CTL0_IDLE_BIT]
  };

  mcgc_state_t r;
  mcgc_state_t n;

  // ==========================================================================
  // FIFO between the data register and the shifter
  logic           fifo_push;
  logic           fifo_wr_ready;
  logic           fifo_rd_valid;
  logic [DW-1:0]  fifo_rd_data;
  logic           fifo_pop;
  logic [LW-1:0]  fifo_level;

  mcgc_fifo #(
    .W     (DW),
    .DEPTH (DEPTH)
  ) mcgc_fifo_i (
    .clk_i      (mclk_i),
    .rst_i      (sys_rst_i),
    .ce_i       (ce_i),
    .wr_valid_i (fifo_push),
    .wr_data_i  (avs_writedata_i[DW-1:0]),
    .wr_ready_o (fifo_wr_ready),
    .rd_valid_o (fifo_rd_valid),
    .rd_data_o  (fifo_rd_data),
    .rd_ready_i (fifo_pop),
    .level_o    (fifo_level)
  );

  // ==========================================================================
  // Address decode and read values
  logic        hit_ctl0;
  logic        hit_ctl1;
  logic        hit_ctl2;
  logic        hit_stat;
  logic        data_wr;
  logic [31:0] ctl0_val;
  logic [31:0] stat_val;
  logic [31:0] read_mux;

  assign hit_ctl0 = (avs_address_i == CTL0_OFFSET);
  assign hit_ctl1 = (avs_address_i == CTL1_OFFSET);
  assign hit_ctl2 = (avs_address_i == CTL2_OFFSET);
  assign hit_stat = (avs_address_i == STAT_OFFSET);
  assign data_wr  = avs_write_i && hit_ctl2 && avs_byteenable_i[0];

  // Control image; unused bit positions read zero
  always_comb begin
    ctl0_val                  = 32'h0000_0000;
    ctl0_val[CTL0_POWER_BIT]  = r.power;
    ctl0_val[CTL0_ORDER_BIT]  = r.lsb_first;
    ctl0_val[CTL0_FORMAT_BIT] = r.plain;
    ctl0_val[CTL0_IDLE_BIT]   = r.idle_lvl;
  end

  // Status image: busy, FIFO empty and full, FIFO fill level
  always_comb begin
    stat_val                 = 32'h0000_0000;
    stat_val[STAT_BUSY_BIT]  = (r.st == MCGC_SEND);
    stat_val[STAT_EMPTY_BIT] = !fifo_rd_valid;
    stat_val[STAT_FULL_BIT]  = !fifo_wr_ready;
    stat_val[STAT_LEVEL_LSB +: LW] = fifo_level;
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit_ctl0) begin
      read_mux = ctl0_val;
    end else if (hit_ctl1) begin
      read_mux = {{(32-DIV_W){1'b0}}, r.half_div};
    end else if (hit_stat) begin
      read_mux = stat_val;
    end
  end

  // Push into the FIFO in the answer cycle of a data write
  assign fifo_push = ce_i && !r.waitreq && data_wr;

  // ==========================================================================
  // Next state: bus slave, then transmitter, then line level
  always_comb begin
    n        = r;
    fifo_pop = 1'b0;
    if (ce_i) begin
      // Bus: request cycle, then one answer cycle with waitrequest low
      if (r.waitreq) begin
        // A data write with a full FIFO waits for room
        if ((avs_read_i || avs_write_i) && !(data_wr && !fifo_wr_ready)) begin
          n.waitreq = 1'b0;
          n.rdata   = avs_read_i ? read_mux : 32'h0000_0000;
        end
      end else begin
        n.waitreq = 1'b1;
        if (avs_write_i && hit_ctl0 && avs_byteenable_i[0]) begin
          // One byte write may change every field at once
          n.power     = avs_writedata_i[CTL0_POWER_BIT];
          n.lsb_first = avs_writedata_i[CTL0_ORDER_BIT];
          n.plain     = avs_writedata_i[CTL0_FORMAT_BIT];
          n.idle_lvl  = avs_writedata_i[CTL0_IDLE_BIT];
        end
        if (avs_write_i && hit_ctl1) begin
          if (avs_byteenable_i[0]) begin
            n.half_div[7:0] = avs_writedata_i[7:0];
          end
          if (avs_byteenable_i[1]) begin
            n.half_div[15:8] = avs_writedata_i[15:8];
          end
        end
      end

      // Transmitter
      if (!r.power) begin
        // Stopped: drop any word in flight, keep the FIFO
        n.st     = MCGC_IDLE;
        n.half   = 1'b0;
        n.cnt    = '0;
        n.bitcnt = '0;
      end else begin
        unique case (r.st)
          MCGC_IDLE: begin
            if (fifo_rd_valid) begin
              fifo_pop = 1'b1;
              n.st     = MCGC_SEND;
              n.shreg  = fifo_rd_data;
              n.bitcnt = BW'(DW - 1);
              n.half   = 1'b0;
              n.cnt    = r.half_div;
            end
          end
          MCGC_SEND: begin
            if (r.cnt != '0) begin
              n.cnt = r.cnt - 1'b1;
            end else if (!r.half) begin
              // Mid-bit
              n.half = 1'b1;
              n.cnt  = r.half_div;
            end else if (r.bitcnt != '0) begin
              // Next bit of the same word
              n.bitcnt = r.bitcnt - 1'b1;
              n.shreg  = r.lsb_first ? {1'b0, r.shreg[DW-1:1]}
                                     : {r.shreg[DW-2:0], 1'b0};
              n.half   = 1'b0;
              n.cnt    = r.half_div;
            end else if (fifo_rd_valid) begin
              // Next word follows without an idle gap
              fifo_pop = 1'b1;
              n.shreg  = fifo_rd_data;
              n.bitcnt = BW'(DW - 1);
              n.half   = 1'b0;
              n.cnt    = r.half_div;
            end else begin
              n.st = MCGC_IDLE;
            end
          end
        endcase
      end

      // Line level for the next cycle
      if (n.st == MCGC_SEND) begin
        if (n.plain) begin
          n.pin = n.lsb_first ? n.shreg[0] : n.shreg[DW-1];
        end else begin
          // First half carries the inverse, second half the bit
          n.pin = (n.lsb_first ? n.shreg[0] : n.shreg[DW-1]) ^ !n.half;
        end
      end else begin
        n.pin = n.idle_lvl;
      end
    end
  end

  // ==========================================================================
  // State register with synchronous reset and clock enable
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      r <= RESET_ST;
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // Outputs straight from flip-flops
  assign avs_readdata_o     = r.rdata;
  assign avs_waitrequest_o  = r.waitreq;
  assign coded_output_pin_o = r.pin;

endmodule // mcgc_top
`default_nettype wire

// ---- bench/mcgc_top_asserts.sv ----
// Checker for the line coder: bus handshake, control readback, idle line.
// Sees only the ports of mcgc_top; bound to it at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module mcgc_top_asserts
  import mcgc_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              sys_rst_i,
  input wire logic              ce_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [31:0]       avs_writedata_i,
  input wire logic [3:0]        avs_byteenable_i,
  input wire logic [31:0]       avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  input wire logic              coded_output_pin_o
);
  // ==========================================================================
  // Shadow of coder_control_0, updated when a write completes
  logic [7:0] ctl_r;
  logic       done_w;
  logic       rd_w;
  assign done_w = ce_i && !avs_waitrequest_o;
  assign rd_w   = done_w && avs_read_i;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctl_r <= CTL0_RESET;
    end else if (done_w && avs_write_i && avs_byteenable_i[0] && avs_address_i == CTL0_OFFSET) begin
      ctl_r <= avs_writedata_i[7:0] & 8'h93;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================================
  // Properties
  a_wait_pulse: assert property ((done_w ##1 ce_i) |-> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_read_answer: assert property ((ce_i && avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("read not answered in one cycle");
  a_write_answer: assert property ((ce_i && avs_write_i && avs_waitrequest_o
    && avs_address_i != CTL2_OFFSET) |=> !avs_waitrequest_o)
    else $error("write not answered in one cycle");
  a_ctl_readback: assert property ((rd_w && avs_address_i == CTL0_OFFSET)
    |-> avs_readdata_o == {24'h00_0000, ctl_r}) else $error("control readback wrong");
  a_map_zero: assert property ((rd_w && avs_address_i != CTL0_OFFSET && avs_address_i != CTL1_OFFSET
    && avs_address_i != STAT_OFFSET) |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped or write-only read not zero");
  a_stop_quiet: assert property ((!ctl_r[7] && !$past(ctl_r[7]) && !$past(ctl_r[7], 2)
    && $stable(ctl_r)) |-> $stable(coded_output_pin_o)) else $error("line moved while stopped");
  a_idle_level: assert property ((!ctl_r[7] && !$past(ctl_r[7]))
    |-> coded_output_pin_o == ctl_r[0]) else $error("stopped line not at idle level");
  a_stop_drop: assert property ($fell(ctl_r[7]) |=> coded_output_pin_o == ctl_r[0])
    else $error("line not idle after stop");
  c_ctl_read: cover property (rd_w && avs_address_i == CTL0_OFFSET);
  c_stop: cover property ($fell(ctl_r[7]));
  c_send: cover property (ctl_r[7] && $changed(coded_output_pin_o));
endmodule // mcgc_top_asserts
bind mcgc_top mcgc_top_asserts mcgc_top_asserts_i (.mclk_i, .sys_rst_i, .ce_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
  .avs_waitrequest_o, .coded_output_pin_o);
`default_nettype wire

// ---- bench/mcgc_rx_model.sv ----
// Receiver model: samples the coded line after a start pulse, decodes one byte.
// Assumes the first half bit shows in the cycle after start is seen.
`timescale 1ns/10ps
`default_nettype none
module mcgc_rx_model #(
  parameter int H = 2
) (
  input  wire logic       mclk_i,
  input  wire logic       start_i,
  input  wire logic       plain_i,
  input  wire logic       coded_i,
  output logic [7:0]      word_o,
  output logic            err_o,
  output logic            done_o
);
  // ==========================================================================
  // One sample per cycle over eight bits
  logic [16*H-1:0] smp_r;
  int              n_r    = 0;
  logic            busy_r = 1'b0;
  always @(posedge mclk_i) begin
    if (busy_r) begin
      smp_r[n_r] <= coded_i;
      n_r        <= n_r + 1;
      busy_r     <= (n_r < 16*H-1);
    end else if (start_i) begin
      busy_r <= 1'b1;
      n_r    <= 0;
    end
  end
  // Bit value and coding fault from the two halves of each bit
  always_comb begin
    err_o = 1'b0;
    for (int i = 0; i < 8; i++) begin
      word_o[i] = plain_i ? smp_r[2*i*H] : smp_r[2*i*H+H];
      err_o     = err_o | (plain_i == (smp_r[2*i*H] != smp_r[2*i*H+H]));
    end
  end
  assign done_o = !busy_r;
endmodule // mcgc_rx_model
`default_nettype wire

// ---- bench/mcgc_top_bench.sv ----
// Testbench for mcgc_top: register access, all line modes, queue fill and drain.
// Assumes the receiver model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module mcgc_top_bench
  import mcgc_pkg::*;
;
  logic        mclk, sys_rst, ce, rd, wr, wait_w, pin, start, plain, err, done;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [7:0]  word;
  int          fail_count = 0;
  int          check_count = 0;
  mcgc_top mcgc_top_i (.mclk_i(mclk), .sys_rst_i(sys_rst), .ce_i(ce), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'h1),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_w), .coded_output_pin_o(pin));
  mcgc_rx_model #(.H(2)) mcgc_rx_model_i (.mclk_i(mclk), .start_i(start), .plain_i(plain),
    .coded_i(pin), .word_o(word), .err_o(err), .done_o(done));
  // ==========================================================================
  // Tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    addr  <= a;
    wdata <= d;
    rd    <= !w;
    wr    <= w;
    @(posedge mclk);
    while (wait_w !== 1'b0) begin
      if (++n > 50) begin
        chk("bus timeout", 0, 1);
        end_sim();
      end
      @(posedge mclk);
    end
    r  = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk); // Gap edge: the next call never re-raises in this step
  endtask
  // ==========================================================================
  // Clock and stimulus
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {sys_rst, ce, rd, wr, start, plain, addr, wdata} = {2'b11, 52'h0_0000_0000_0000};
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    bus(CTL0_OFFSET, 0, 0, q); chk("ctl0 reset", 32'h0000_0010, q);
    bus(CTL1_OFFSET, 0, 0, q); chk("ctl1 reset", 32'h0000_0031, q);
    bus(CTL0_OFFSET, 1, 32'h0000_00ff, q);
    bus(CTL0_OFFSET, 0, 0, q); chk("ctl0 fixed zeros", 32'h0000_0093, q);
    chk("idle high", 32'h0000_0001, {31'h0000_0000, pin});
    bus(16'hff60, 0, 0, q); chk("unmapped", 32'h0000_0000, q);
    bus(CTL1_OFFSET, 1, 32'h0000_0001, q);
    bus(CTL1_OFFSET, 0, 0, q); chk("divider", 32'h0000_0001, q);
    $display("test registers done");
    // Every order, format and idle level, one byte each
    for (int m = 0; m < 8; m++) begin
      bus(CTL0_OFFSET, 1, 32'h0000_0000, q);
      bus(CTL0_OFFSET, 1, {24'h00_0000, 1'b1, 2'b00, m[0], 2'b00, m[1], m[2]}, q);
      chk("idle", {31'h0000_0000, m[2]}, {31'h0000_0000, pin});
      plain <= m[1];
      bus(CTL2_OFFSET, 1, 32'h0000_00c5, q);
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      @(posedge mclk);
      for (int n = 0; n < 100 && done !== 1'b1; n++) @(posedge mclk);
      chk("rx done", 32'h0000_0001, {31'h0000_0000, done});
      chk("word", {24'h00_0000, m[0] ? 8'hc5 : 8'ha3}, {24'h00_0000, word});
      chk("coding", 0, {31'h0000_0000, err});
      chk("idle after", {31'h0000_0000, m[2]}, {31'h0000_0000, pin});
    end
    $display("test modes done");
    // Fill the queue while stopped, then stop in mid-word and drain
    bus(CTL0_OFFSET, 1, 32'h0000_0000, q);
    for (int i = 0; i < 8; i++) bus(CTL2_OFFSET, 1, i, q);
    bus(STAT_OFFSET, 0, 0, q); chk("full", 32'h0000_0804, q);
    chk("held idle", 0, {31'h0000_0000, pin});
    bus(CTL0_OFFSET, 1, 32'h0000_0080, q);
    repeat (5) @(posedge mclk);
    bus(STAT_OFFSET, 0, 0, q); chk("busy", 32'h0000_0701, q);
    // Clock enable low: the line must hold still in mid-word
    ce <= 1'b0;
    @(posedge mclk);
    q = {31'h0000_0000, pin};
    repeat (20) @(posedge mclk);
    chk("frozen line", q, {31'h0000_0000, pin});
    ce <= 1'b1;
    bus(CTL0_OFFSET, 1, 32'h0000_0000, q);
    bus(STAT_OFFSET, 0, 0, q); chk("dropped word", 32'h0000_0700, q);
    chk("stopped idle", 0, {31'h0000_0000, pin});
    bus(CTL0_OFFSET, 1, 32'h0000_0080, q);
    for (int n = 0; n < 200 && q !== 32'h0000_0002; n++) bus(STAT_OFFSET, 0, 0, q);
    chk("drained", 32'h0000_0002, q);
    $display("test queue done");
    end_sim();
  end
endmodule // mcgc_top_bench
`default_nettype wire
